// ===== hdl/cbd_defs.svh
// register offsets, reset values, field positions and constants of the decode block
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH
`define CBD_REG_INSTR 8'h00
`define CBD_REG_OPA 8'h04
`define CBD_REG_OPB 8'h08
`define CBD_REG_OPS 8'h0C
`define CBD_REG_SHC 8'h10
`define CBD_REG_RESULT 8'h14
`define CBD_REG_STATUS 8'h18
`define CBD_REG_PC 8'h1C
`define CBD_REG_LINK 8'h20
`define CBD_REG_STATE 8'h24
`define CBD_PC_RESET 32'h0000_0000
`define CBD_MODE_SVC 5'h13
`define CBD_WORD 32'h0000_0004
`define CBD_PREFETCH 32'h0000_0008
`define CBD_ALL_ONES 32'hFFFF_FFFF
`define CBD_LINK_IDX 4'hE
`define CBD_COND_ALWAYS 4'hE
`define CBD_BIT_N 31
`define CBD_BIT_Z 30
`define CBD_BIT_C 29
`define CBD_BIT_V 28
`define CBD_BIT_I 7
`define CBD_BIT_F 6
`endif

// ===== hdl/cbd_pkg.sv
// types shared by the condition and branch decode block
package cbd_pkg;
	// sequencer states; only the swap takes more than one cycle
	typedef enum logic [1:0] {ST_IDLE, ST_SWAP_RD, ST_SWAP_WR} cbd_state_type;
	// data processing opcodes
	typedef enum logic [3:0] {
		OP_AND, OP_XOR, OP_SUB, OP_RSUB, OP_ADD, OP_ADC, OP_SUB_CARRY, OP_RSUB_CARRY,
		OP_TEST_AND, OP_TEST_XOR, OP_COMPARE_SUB, OP_COMPARE_ADD, OP_OR, OP_MOV, OP_BIT_CLEAR,
		OP_MOVE_INV
	} cbd_dp_op_type;
	// instruction classes this block executes
	typedef enum logic [2:0] {CL_DP, CL_MULTIPLY, CL_SWAP, CL_BRANCH, CL_NONE} cbd_class_type;
	// register write-back port
	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic [31:0] data;
	} cbd_wb_type;
	// locked memory access for the swap
	typedef struct packed {
		logic rd;
		logic wr;
		logic lock;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cbd_mem_type;
endpackage : cbd_pkg

// ===== hdl/cbd_decode.sv
// condition check, branch and result execution for one instruction at a time
//
// Behaviour
// [RQ1] execute only when condition bits pass
// [RQ2] source never issues reserved all-ones condition
// [RQ3] codes 0000-0111 test one flag each
// [RQ4] 1000 higher, 1001 lower or same
// [RQ5] signed compares from negative, overflow, zero
// [RQ6] 1110 always executes
// [RQ7] offset shifted two, sign extended, added
// [RQ8] branch base is pc plus eight
// [RQ9] link gets address after the branch
// [RQ10] link low bits zero, status not saved
// [RQ11] plain branch leaves link untouched
// [RQ12] bit 6 multiply does nothing, no trap
// [RQ13] add, add-carry, subtract, reverse subtract results
// [RQ14] subtract and reverse subtract with carry
// [RQ15] compares and tests touch flags only
// [RQ16] logical results, move and bit clear
// [RQ17] move inverted is all ones xor operand
// [RQ18] multiply and multiply-accumulate results
// [RQ19] swap reads then writes same address, locked
// [RQ20] reset: pc zero, supervisor, interrupts disabled
// [RQ21] failed condition changes nothing, pc advances
`timescale 1ns/100ps
`include "cbd_defs.svh"
module cbd_decode import cbd_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic [31:0] mem_rdata,
	output cbd_mem_type mem_out,
	output cbd_wb_type wb_out,
	output logic [31:0] program_counter_reg,
	output logic [31:0] link_register,
	output logic [31:0] current_status_word
);
	// condition evaluation, used by execution and by checks
	function automatic logic cond_pass(input logic [3:0] cond, input logic [31:0] sw);
		logic n;
		logic z;
		logic c;
		logic v;
		n = sw[`CBD_BIT_N];
		z = sw[`CBD_BIT_Z];
		c = sw[`CBD_BIT_C];
		v = sw[`CBD_BIT_V];
		unique case (cond)
			4'h0, 4'h1: cond_pass = z ^ cond[0]; // RQ3
			4'h2, 4'h3: cond_pass = c ^ cond[0]; // RQ3
			4'h4, 4'h5: cond_pass = n ^ cond[0]; // RQ3
			4'h6, 4'h7: cond_pass = v ^ cond[0]; // RQ3
			4'h8: cond_pass = c & ~z; // RQ4
			4'h9: cond_pass = ~c | z; // RQ4
			4'hA: cond_pass = (n == v); // RQ5
			4'hB: cond_pass = (n != v); // RQ5
			4'hC: cond_pass = ~z & (n == v); // RQ5
			4'hD: cond_pass = z | (n != v); // RQ5
			4'hE: cond_pass = 1'b1; // RQ6
			4'hF: cond_pass = 1'b0; // reserved, never issued RQ2
		endcase
	endfunction : cond_pass

	// classify an instruction word
	function automatic cbd_class_type classify(input logic [31:0] ins);
		if (ins[27:25] == 3'b101) begin
			classify = CL_BRANCH;
		end else if (ins[27:22] == 6'h00 && ins[7:4] == 4'h9) begin
			classify = CL_MULTIPLY;
		end else if (ins[27:23] == 5'h02 && ins[21:20] == 2'h0 && ins[11:4] == 8'h09) begin
			classify = CL_SWAP;
		end else if (ins[27:26] == 2'h0 && !(ins[25] == 1'b0 && ins[7] && ins[4])) begin
			classify = CL_DP;
		end else begin
			// includes multiply with bit 6 set: silently does nothing RQ12
			classify = CL_NONE;
		end
	endfunction : classify

	cbd_state_type state_reg; // sequencer state
	logic [31:0] instr_reg; // last issued instruction
	logic [31:0] opa_reg; // first operand value
	logic [31:0] opb_reg; // second operand or source_reg_m value
	logic [31:0] ops_reg; // source_reg_s value
	logic shc_reg; // shifter carry for logical ops
	logic [31:0] result_reg; // last computed result
	logic pass_reg; // last condition outcome
	logic issue; // instruction write accepted
	logic pass; // condition of the issued word
	cbd_class_type cls; // class of the issued word
	cbd_dp_op_type dp_op; // opcode field
	logic [32:0] sum; // 33-bit adder with carry out
	logic [31:0] add_x; // adder inputs
	logic [31:0] add_y;
	logic add_cin;
	logic [31:0] dp_result; // data processing result
	logic [3:0] nzcv_next; // flags after the operation
	logic is_logic; // logical class sets carry from shifter
	logic is_test; // no destination write
	logic [31:0] branch_target; // computed branch destination

	// write to the instruction register starts execution; ignored while a swap runs
	assign issue = bus_wr && bus_addr == `CBD_REG_INSTR && state_reg == ST_IDLE;
	assign pass = cond_pass(bus_wdata[31:28], current_status_word); // RQ1
	assign cls = classify(bus_wdata);
	assign dp_op = cbd_dp_op_type'(bus_wdata[24:21]);
	assign is_test = dp_op inside {OP_TEST_AND, OP_TEST_XOR, OP_COMPARE_SUB, OP_COMPARE_ADD}; // RQ15
	assign is_logic = dp_op inside {OP_AND, OP_XOR, OP_TEST_AND, OP_TEST_XOR, OP_OR, OP_MOV,
		OP_BIT_CLEAR, OP_MOVE_INV};
	// pc plus eight as base, offset times four sign extended RQ7 RQ8
	assign branch_target = program_counter_reg + `CBD_PREFETCH
		+ {{6{bus_wdata[23]}}, bus_wdata[23:0], 2'b00}; // RQ7

	// one adder serves every arithmetic data-processing op; subtraction by inverted input plus carry
	always_comb begin
		add_x = opa_reg;
		add_y = opb_reg;
		add_cin = 1'b0;
		unique case (dp_op)
			OP_SUB, OP_COMPARE_SUB: begin
				add_y = ~opb_reg; // RQ13
				add_cin = 1'b1;
			end
			OP_RSUB: begin
				add_x = opb_reg; // RQ13
				add_y = ~opa_reg;
				add_cin = 1'b1;
			end
			OP_ADC: add_cin = current_status_word[`CBD_BIT_C]; // RQ13
			OP_SUB_CARRY: begin
				add_y = ~opb_reg; // minus one plus carry RQ14
				add_cin = current_status_word[`CBD_BIT_C];
			end
			OP_RSUB_CARRY: begin
				add_x = opb_reg; // RQ14
				add_y = ~opa_reg;
				add_cin = current_status_word[`CBD_BIT_C];
			end
			default: add_cin = 1'b0; // plain add and compare-add; logical ops ignore it
		endcase
	end
	assign sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0000_0000, add_cin};

	// result select and flag computation
	always_comb begin
		unique case (dp_op)
			OP_AND, OP_TEST_AND: dp_result = opa_reg & opb_reg; // RQ16 RQ15
			OP_XOR, OP_TEST_XOR: dp_result = opa_reg ^ opb_reg; // RQ16 RQ15
			OP_OR: dp_result = opa_reg | opb_reg; // RQ16
			OP_MOV: dp_result = opb_reg; // RQ16
			OP_BIT_CLEAR: dp_result = opa_reg & ~opb_reg; // RQ16
			OP_MOVE_INV: dp_result = `CBD_ALL_ONES ^ opb_reg; // RQ17
			default: dp_result = sum[31:0]; // RQ13 RQ14
		endcase
		nzcv_next[3] = dp_result[31];
		nzcv_next[2] = (dp_result == 32'h0000_0000);
		if (is_logic) begin
			// logical class: carry from shifter, overflow kept
			nzcv_next[1] = shc_reg;
			nzcv_next[0] = current_status_word[`CBD_BIT_V];
		end else begin
			nzcv_next[1] = sum[32];
			nzcv_next[0] = (add_x[31] == add_y[31]) && (sum[31] != add_x[31]);
		end
	end

	// operand registers written by software
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			opa_reg <= 32'h0000_0000;
			opb_reg <= 32'h0000_0000;
			ops_reg <= 32'h0000_0000;
			shc_reg <= 1'b0;
		end else if (bus_wr) begin
			unique case (bus_addr)
				`CBD_REG_OPA: opa_reg <= bus_wdata;
				`CBD_REG_OPB: opb_reg <= bus_wdata;
				`CBD_REG_OPS: ops_reg <= bus_wdata;
				`CBD_REG_SHC: shc_reg <= bus_wdata[0];
				default: shc_reg <= shc_reg; // other addresses hold operands
			endcase
		end
	end

	// program counter: branch target or next word, also on a failed condition
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			program_counter_reg <= `CBD_PC_RESET; // RQ20
		end else if (issue) begin
			if (pass && cls == CL_BRANCH) begin
				program_counter_reg <= branch_target; // RQ7 RQ8
			end else begin
				program_counter_reg <= program_counter_reg + `CBD_WORD; // RQ21
			end
		end
	end

	// link register of the active bank; only a taken branch with link writes it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			link_register <= 32'h0000_0000;
		end else if (issue && pass && cls == CL_BRANCH && bus_wdata[24]) begin
			// next instruction address, low bits forced clear RQ9 RQ10
			link_register <= {program_counter_reg[31:2] + 30'h0000_0001, 2'b00}; // RQ9 RQ10
		end
		// plain branch falls through and keeps the link RQ11
	end

	// status word; flags change only on a passing data op with the s bit or a passing compare or test op
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			current_status_word <= 32'h0000_0000;
			current_status_word[`CBD_BIT_I] <= 1'b1; // RQ20
			current_status_word[`CBD_BIT_F] <= 1'b1; // RQ20
			current_status_word[4:0] <= `CBD_MODE_SVC; // RQ20
		end else if (issue && pass && cls == CL_DP && (bus_wdata[20] || is_test)) begin
			current_status_word[31:28] <= nzcv_next; // RQ15
		end
		// branch with link does not touch the status word RQ10
	end

	// result and write-back port
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wb_out <= '0;
			result_reg <= 32'h0000_0000;
		end else begin
			wb_out.valid <= 1'b0;
			if (issue && pass && cls == CL_DP) begin
				result_reg <= dp_result;
				wb_out.valid <= !is_test; // RQ15
				wb_out.index <= bus_wdata[15:12];
				wb_out.data <= dp_result; // RQ13 RQ16
			end else if (issue && pass && cls == CL_MULTIPLY) begin
				// low word of product, plus accumulator when bit 21 set
				result_reg <= opb_reg * ops_reg + (bus_wdata[21] ? opa_reg : 32'h0000_0000);
				wb_out.valid <= 1'b1;
				wb_out.index <= bus_wdata[19:16];
				wb_out.data <= opb_reg * ops_reg
					+ (bus_wdata[21] ? opa_reg : 32'h0000_0000); // RQ18
			end else if (state_reg == ST_SWAP_WR) begin
				result_reg <= mem_rdata;
				wb_out.valid <= 1'b1;
				wb_out.index <= instr_reg[15:12];
				wb_out.data <= mem_rdata; // RQ19
			end
		end
	end

	// swap sequencer: locked read then write to the base address
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			mem_out <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					mem_out <= '0;
					if (issue && pass && cls == CL_SWAP) begin
						state_reg <= ST_SWAP_RD;
						mem_out.rd <= 1'b1; // RQ19
						mem_out.lock <= 1'b1;
						mem_out.addr <= opa_reg;
						mem_out.wdata <= opb_reg;
					end
				end
				ST_SWAP_RD: begin
					// read data arrive next cycle; store keeps the lock
					state_reg <= ST_SWAP_WR;
					mem_out.rd <= 1'b0;
					mem_out.wr <= 1'b1; // RQ19
				end
				ST_SWAP_WR: begin
					state_reg <= ST_IDLE;
					mem_out <= '0;
				end
			endcase
		end
	end

	// last instruction and condition outcome, kept for software
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			instr_reg <= 32'h0000_0000;
			pass_reg <= 1'b0;
		end else if (issue) begin
			instr_reg <= bus_wdata;
			pass_reg <= pass;
		end
	end

	// read port: data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_rd) begin
			unique case (bus_addr)
				`CBD_REG_INSTR: bus_rdata <= instr_reg;
				`CBD_REG_OPA: bus_rdata <= opa_reg;
				`CBD_REG_OPB: bus_rdata <= opb_reg;
				`CBD_REG_OPS: bus_rdata <= ops_reg;
				`CBD_REG_SHC: bus_rdata <= {31'h0000_0000, shc_reg};
				`CBD_REG_RESULT: bus_rdata <= result_reg;
				`CBD_REG_STATUS: bus_rdata <= current_status_word;
				`CBD_REG_PC: bus_rdata <= program_counter_reg;
				`CBD_REG_LINK: bus_rdata <= link_register;
				`CBD_REG_STATE: bus_rdata <= {30'h0000_0000, pass_reg, state_reg != ST_IDLE};
				default: bus_rdata <= 32'h0000_0000;
			endcase
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_cond_fail_holds: assert property (issue && !pass |=> // RQ21
		program_counter_reg == $past(program_counter_reg) + `CBD_WORD
		&& $stable(current_status_word) && $stable(link_register) && !wb_out.valid
		&& state_reg == ST_IDLE) else $error("failed condition changed state");
	a_always_passes: assert property (issue && bus_wdata[31:28] == `CBD_COND_ALWAYS // RQ6
		|-> pass) else $error("always condition did not pass");
	a_branch_target: assert property (issue && pass && cls == CL_BRANCH |=> // RQ7
		program_counter_reg == $past(program_counter_reg) + 32'h0000_0008
		+ {{6{$past(bus_wdata[23])}}, $past(bus_wdata[23:0]), 2'b00})
		else $error("branch target wrong");
	a_link_value: assert property (issue && pass && cls == CL_BRANCH && bus_wdata[24] |=> // RQ9
		link_register == (($past(program_counter_reg) + 32'h0000_0004) & 32'hFFFF_FFFC)
		&& link_register[1:0] == 2'b00) else $error("link value wrong");
	a_plain_branch: assert property (issue && cls == CL_BRANCH && !bus_wdata[24] |=> // RQ11
		$stable(link_register) && $stable(current_status_word)) else $error("link touched");
	a_test_no_write: assert property (issue && pass && cls == CL_DP && is_test |=> // RQ15
		!wb_out.valid) else $error("test op wrote a register");
	a_move_inverted: assert property (issue && pass && cls == CL_DP // RQ17
		&& dp_op == OP_MOVE_INV |=> wb_out.valid && wb_out.data == ~$past(opb_reg))
		else $error("move inverted result wrong");
	a_add_carry: assert property (issue && pass && cls == CL_DP && dp_op == OP_ADC |=> // RQ13
		wb_out.data == $past(opa_reg) + $past(opb_reg)
		+ {31'h0000_0000, $past(current_status_word[`CBD_BIT_C])})
		else $error("add with carry wrong");
	a_multiply_acc: assert property (issue && pass && cls == CL_MULTIPLY && bus_wdata[21] |=> // RQ18
		wb_out.data == $past(opb_reg) * $past(ops_reg) + $past(opa_reg))
		else $error("multiply accumulate wrong");
	a_swap_order: assert property (issue && pass && cls == CL_SWAP |=> // RQ19
		mem_out.rd && mem_out.lock && !mem_out.wr ##1 mem_out.wr && mem_out.lock
		&& mem_out.addr == $past(opa_reg, 2) ##1 wb_out.valid && !mem_out.lock)
		else $error("swap sequence wrong");
	a_reset_state: assert property (disable iff (1'b0) !rst_n |=> // RQ20
		program_counter_reg == 32'h0000_0000 && current_status_word[4:0] == 5'h13
		&& current_status_word[`CBD_BIT_I] && current_status_word[`CBD_BIT_F])
		else $error("reset state wrong");
endmodule : cbd_decode

// ===== sim/cbd_decode_tb_top.sv
// self-checking bench for the condition and branch decode block
`timescale 1ns/100ps
module cbd_decode_tb_top import cbd_pkg::*; ();
	// one ordinary data-processing case
	typedef struct {
		logic [3:0] op; // opcode field
		logic cin; // carry flag before the op
		logic wv; // destination written
		logic [31:0] res; // expected result
	} cbd_row_type;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	logic [31:0] mem_rdata = 32'h5A5A_A5A5; // idle memory shows a pattern, not zero
	cbd_mem_type mem_out;
	cbd_wb_type wb_out;
	logic [31:0] program_counter_reg;
	logic [31:0] link_register;
	logic [31:0] current_status_word;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] exp_pc = 32'h0000_0000; // model of the next fetch address
	logic [31:0] exp_link = 32'h0000_0000;
	logic [31:0] rdv;
	logic [3:0] exp_f; // expected flags of the current compare pair
	logic pass_exp; // expected condition outcome
	cbd_row_type cur; // row under test
	// compare pairs: zero, negative, signed overflow, plain, negative with overflow
	logic [31:0] fa [5] = '{32'h0000_0005, 32'h0000_0003, 32'h8000_0000, 32'h0000_0005,
		32'h7FFF_FFFF};
	logic [31:0] fb [5] = '{32'h0000_0005, 32'h0000_0005, 32'h0000_0001, 32'h0000_0003,
		32'hFFFF_FFFF};
	// operands 0xF0 and 0x3C; the last row leaves zero and carry set
	cbd_row_type rows [19] = '{
		'{4'h0, 1'b1, 1'b1, 32'h0000_0030}, '{4'h1, 1'b1, 1'b1, 32'h0000_00CC},
		'{4'h2, 1'b1, 1'b1, 32'h0000_00B4}, '{4'h3, 1'b1, 1'b1, 32'hFFFF_FF4C},
		'{4'h4, 1'b0, 1'b1, 32'h0000_012C}, '{4'h5, 1'b0, 1'b1, 32'h0000_012C},
		'{4'h5, 1'b1, 1'b1, 32'h0000_012D}, '{4'h6, 1'b0, 1'b1, 32'h0000_00B3},
		'{4'h6, 1'b1, 1'b1, 32'h0000_00B4}, '{4'h7, 1'b0, 1'b1, 32'hFFFF_FF4B},
		'{4'h7, 1'b1, 1'b1, 32'hFFFF_FF4C}, '{4'h8, 1'b1, 1'b0, 32'h0000_0000},
		'{4'h9, 1'b1, 1'b0, 32'h0000_0000}, '{4'hA, 1'b0, 1'b0, 32'h0000_0000},
		'{4'hB, 1'b1, 1'b0, 32'h0000_0000}, '{4'hC, 1'b1, 1'b1, 32'h0000_00FC},
		'{4'hD, 1'b1, 1'b1, 32'h0000_003C}, '{4'hE, 1'b1, 1'b1, 32'h0000_00C0},
		'{4'hF, 1'b1, 1'b1, 32'hFFFF_FFC3}};

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	cbd_decode dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.mem_rdata(mem_rdata), .mem_out(mem_out), .wb_out(wb_out),
		.program_counter_reg(program_counter_reg), .link_register(link_register),
		.current_status_word(current_status_word));

	// counts every comparison, reports a mismatch at once
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// ends the run from one place only
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	// one-cycle write strobe; a clock edge passes before the next one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask : rd
	// issue one instruction; step is the expected move of the fetch address
	task automatic run(input logic [31:0] i, input logic [31:0] step, input logic ck,
		input logic wv, input logic [31:0] res);
		wr(8'h00, i);
		#1;
		exp_pc = exp_pc + step;
		chk("pc", exp_pc, program_counter_reg);
		if (ck) begin
			chk("wb valid", {31'h0000_0000, wv}, {31'h0000_0000, wb_out.valid});
			if (wv) chk("wb data", res, wb_out.data);
		end
	endtask : run
	// hold reset low, then check the start-up state
	task automatic do_reset(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
		chk("pc", 32'h0000_0000, program_counter_reg);
		chk("status", 32'h0000_00D3, current_status_word);
		chk("link", 32'h0000_0000, link_register);
		chk("wb valid", 32'h0000_0000, {31'h0000_0000, wb_out.valid});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		exp_pc = 32'h0000_0000;
		exp_link = 32'h0000_0000;
	endtask : do_reset
	// data-processing word, first operand index 1, destination index 3
	function automatic logic [31:0] dp_i(input logic [3:0] c, input logic [3:0] op,
		input logic s);
		return {c, 3'h0, op, s, 4'h1, 4'h3, 12'h000};
	endfunction : dp_i
	// flags n z c v of a minus b
	function automatic logic [3:0] cmp_f(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] d;
		d = {1'b0, a} + {1'b0, ~b} + 33'h0_0000_0001;
		return {d[31], d[31:0] == 32'h0000_0000, d[32], (a[31] != b[31]) && (d[31] != a[31])};
	endfunction : cmp_f
	// condition pass from field and flags
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic n, z, cy, v;
		{n, z, cy, v} = f;
		case (c)
			4'h0: return z;
			4'h1: return !z;
			4'h2: return cy;
			4'h3: return !cy;
			4'h4: return n;
			4'h5: return !n;
			4'h6: return v;
			4'h7: return !v;
			4'h8: return cy && !z;
			4'h9: return !cy || z;
			4'hA: return n == v;
			4'hB: return n != v;
			4'hC: return !z && (n == v);
			4'hD: return z || (n != v);
			default: return 1'b1;
		endcase
	endfunction : cond_ok

	// a hang counts as a mismatch
	initial begin
		#400000;
		n_errors++;
		$display("wrong value run time: expected end, seen timeout");
		give_verdict();
	end

	// main sequence
	initial begin
		do_reset(10);
		$display("test done: reset");
		foreach (fa[j]) begin
			wr(8'h04, fa[j]);
			wr(8'h08, fb[j]);
			exp_f = cmp_f(fa[j], fb[j]);
			run(dp_i(4'hE, 4'hA, 1'b1), 32'h0000_0004, 1'b1, 1'b0, 32'h0000_0000);
			chk("flags", {exp_f, 28'h000_00D3}, current_status_word);
			// the all-ones code is reserved, so the loop stops short of it
			for (int c = 0; c < 15; c++) begin
				pass_exp = cond_ok(c[3:0], exp_f);
				run(dp_i(c[3:0], 4'h4, 1'b0), 32'h0000_0004, 1'b1, pass_exp, fa[j] + fb[j]);
			end
		end
		$display("test done: conditions");
		foreach (rows[k]) begin
			cur = rows[k];
			wr(8'h04, cur.cin ? 32'h0000_0005 : 32'h0000_0003);
			wr(8'h08, 32'h0000_0005);
			run(dp_i(4'hE, 4'hA, 1'b1), 32'h0000_0004, 1'b0, 1'b0, 32'h0000_0000);
			wr(8'h04, 32'h0000_00F0);
			wr(8'h08, 32'h0000_003C);
			run(dp_i(4'hE, cur.op, 1'b0), 32'h0000_0004, 1'b1, cur.wv, cur.res);
			if (cur.wv) chk("wb index", 32'h0000_0003, {28'h000_0000, wb_out.index});
		end
		$display("test done: data processing");
		wr(8'h04, 32'h0000_0007);
		wr(8'h08, 32'h0001_0003);
		wr(8'h0C, 32'h0000_0005);
		run(32'hE002_1496, 32'h0000_0004, 1'b1, 1'b1, 32'h0005_000F);
		chk("wb index", 32'h0000_0002, {28'h000_0000, wb_out.index});
		run(32'hE022_1496, 32'h0000_0004, 1'b1, 1'b1, 32'h0005_0016);
		run(32'hE002_14D6, 32'h0000_0004, 1'b1, 1'b0, 32'h0000_0000);
		$display("test done: multiply");
		wr(8'h04, 32'h0000_0100);
		wr(8'h08, 32'hA5A5_0F0F);
		wr(8'h00, 32'hE101_5096);
		mem_rdata <= 32'h1234_5678;
		#1;
		chk("mem rd lock", 32'h0000_0003, {30'h0000_0000, mem_out.rd, mem_out.lock});
		chk("mem addr", 32'h0000_0100, mem_out.addr);
		chk("mem wdata", 32'hA5A5_0F0F, mem_out.wdata);
		// an instruction written mid-swap must be dropped
		fork
			wr(8'h00, dp_i(4'hE, 4'h4, 1'b0));
			begin
				@(posedge clk_sys);
				#1;
				chk("mem wr lock", 32'h0000_0003, {30'h0000_0000, mem_out.wr, mem_out.lock});
			end
		join
		mem_rdata <= 32'hEDCB_A987;
		#1;
		chk("swap valid", 32'h0000_0001, {31'h0000_0000, wb_out.valid});
		chk("swap data", 32'h1234_5678, wb_out.data);
		chk("swap index", 32'h0000_0005, {28'h000_0000, wb_out.index});
		@(posedge clk_sys);
		#1;
		exp_pc = exp_pc + 32'h0000_0004;
		chk("pc", exp_pc, program_counter_reg);
		chk("wb valid", 32'h0000_0000, {31'h0000_0000, wb_out.valid});
		$display("test done: swap");
		run(32'hEA00_0010, 32'h0000_0048, 1'b0, 1'b0, 32'h0000_0000);
		chk("link", exp_link, link_register);
		exp_link = exp_pc + 32'h0000_0004;
		// backward branch: minus 0x40 offset plus the prefetch of eight
		run(32'hEBFF_FFF0, 32'hFFFF_FFC8, 1'b0, 1'b0, 32'h0000_0000);
		chk("link", exp_link, link_register);
		run(32'h1B00_0004, 32'h0000_0004, 1'b0, 1'b0, 32'h0000_0000);
		chk("link", exp_link, link_register);
		chk("status", 32'h6000_00D3, current_status_word);
		$display("test done: branch");
		wr(8'h1C, 32'hDEAD_BEEF);
		rd(8'h1C, rdv);
		chk("pc reg", exp_pc, rdv);
		rd(8'h20, rdv);
		chk("link reg", exp_link, rdv);
		rd(8'h18, rdv);
		chk("status reg", 32'h6000_00D3, rdv);
		rd(8'h24, rdv);
		chk("state reg", 32'h0000_0000, rdv);
		rd(8'hFC, rdv);
		chk("unmapped", 32'h0000_0000, rdv);
		rd(8'h14, rdv);
		chk("result reg", 32'h1234_5678, rdv);
		rd(8'h00, rdv);
		chk("instr reg", 32'h1B00_0004, rdv);
		$display("test done: register bus");
		// logical op with s bit: carry from the shifter register, overflow kept
		wr(8'h10, 32'h0000_0001);
		run(dp_i(4'hE, 4'h0, 1'b1), 32'h0000_0004, 1'b1, 1'b1, 32'h0000_0100);
		chk("status", 32'h2000_00D3, current_status_word);
		$display("test done: logical flags");
		// reset taken on an edge, then the first instruction right after release
		@(posedge clk_sys);
		do_reset(2);
		run(dp_i(4'hE, 4'h4, 1'b0), 32'h0000_0004, 1'b1, 1'b1, 32'h0000_0000);
		$display("test done: second reset");
		give_verdict();
	end
endmodule : cbd_decode_tb_top
